// file: design/pnpiso_defines.svh
// Constants for the plug and play isolation block
`ifndef PNPISO_DEFINES_SVH
`define PNPISO_DEFINES_SVH
`define PNPISO_ID_BITS       72
`define PNPISO_PAIRS         8'd72
`define PNPISO_DRIVE_FIRST   8'h55
`define PNPISO_DRIVE_SECOND  8'haa
`define PNPISO_SENSE_FIRST   2'b01
`define PNPISO_SENSE_SECOND  2'b10
`define PNPISO_SRAM_BYTES    64
`define PNPISO_FIXED_START   6'd1
`define PNPISO_WAKE_ISOLATE  8'h00
`define PNPISO_FIFO_DEPTH    16
`endif

// file: design/pnpiso_pkg.sv
// Types for the plug and play isolation block
package pnpiso_pkg;
    typedef enum logic [1:0] {
        WAIT_KEY,
        SLEEP,
        ISOLATE,
        CONFIG
    } pnpiso_state_type;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } pnpiso_load_type;
endpackage

// file: design/pnpiso_fifo.sv
// Small synchronous FIFO for the microcontroller load path
`timescale 1ns/1ps
module pnpiso_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_param_check
        $error("pnpiso_fifo: DEPTH must be a power of two of at least 2, WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst) // R16
        (wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
        else $error("fifo fill level exceeds depth");
endmodule // pnpiso_fifo

// file: design/pnpiso_card.sv
// Card side isolation, state machine and identifier store
`timescale 1ns/1ps
`include "pnpiso_defines.svh"

// Notes on behaviour
// R1: Card holds 72-bit non-zero identifier.
// R2: Bytes shift out bit 0 first.
// R3: Isolation handles 72 read pairs.
// R4: First read: one drives 55h, zero senses 01.
// R5: Second read: drive aah, sensers check 10.
// R6: Sensing both patterns drops card this iteration.
// R7: Drive eight lines, compare only two.
// R8: Driver or unopposed card advances one bit.
// R9: Numbered cards skip isolation; commands need number.
// R10: Host records ones, checks checksum.
// R11: Host relocates conflicting read port.
// R12: Host ends isolation when pattern missing.
// R13: Host waits 1 ms then 250 ms.
// R14: Reset or wait command returns to key wait.
// R15: Reset-number clears all; vendor clear ours.
// R16: Microcontroller loads length, identifier, resources.
// R17: Resource read returns byte, increments, wraps.
// R18: Power-up clears number; host waits 2 ms.
// R19: Key wait ignores accesses until key.
// R20: Wake 00h isolates; wake resets pointer.
// R21: Number assigned enters config; wake 0 sleeps.
// R22: Resource data readable only in config.
module pnpiso_card #(
    parameter int FIFO_DEPTH = `PNPISO_FIFO_DEPTH
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      key_detected,
    input  wire logic                      wait_key_cmd,
    input  wire logic                      wake_cmd,
    input  wire logic [7:0]                wake_data,
    input  wire logic                      csn_write,
    input  wire logic [7:0]                csn_data,
    input  wire logic                      reset_csn_cmd,
    input  wire logic                      vendor_select_number_clear,
    input  wire logic                      iso_read,
    input  wire logic                      res_read,
    input  wire logic [1:0]                sd_in,
    output logic      [7:0]                sd_out,
    output logic                           sd_oe,
    input  wire logic                      load_valid,
    output logic                           load_ready,
    input  wire pnpiso_pkg::pnpiso_load_type load_word,
    output pnpiso_pkg::pnpiso_state_type   card_state,
    output logic      [7:0]                csn,
    output logic                           cmd_enabled
);
    // Refused at elaboration, since the FIFO cannot work with fewer than two words
    if (FIFO_DEPTH < 2)
    begin : g_depth_check
        $error("pnpiso_card: FIFO_DEPTH too small");
    end

    pnpiso_pkg::pnpiso_state_type state_reg;
    pnpiso_pkg::pnpiso_state_type state_next;
    logic [7:0]  sram [`PNPISO_SRAM_BYTES];
    logic [7:0]  csn_reg;
    logic [5:0]  ptr_reg;
    logic [2:0]  bit_reg;
    logic        half_reg;
    logic        lost_reg;
    logic        drove_reg;
    logic        sensed_reg;
    logic [7:0]  pair_cnt_reg;
    logic [7:0]  sd_out_reg;
    logic        sd_oe_reg;
    logic [1:0]  sd_meta_reg;
    logic [1:0]  sd_sync_reg;
    logic        fifo_valid;
    pnpiso_pkg::pnpiso_load_type fifo_word;

    // Load path is buffered so a slow microcontroller can stream while reads proceed
    pnpiso_fifo #(
        .WIDTH ($bits(pnpiso_pkg::pnpiso_load_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (load_valid),
        .in_ready  (load_ready),
        .in_data   (load_word),
        .out_valid (fifo_valid),
        .out_ready (1'b1),
        .out_data  (fifo_word)
    );

    // SRAM writes drain one per cycle
    always_ff @(posedge clk)
    begin
        if (fifo_valid)
            sram[fifo_word.addr] <= fifo_word.data; // R16
    end

    // Data bus comes from another clock domain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sd_meta_reg <= 2'b00;
            sd_sync_reg <= 2'b00;
        end
        else
        begin
            sd_meta_reg <= sd_in;
            sd_sync_reg <= sd_meta_reg;
        end
    end

    // Byte 0 holds length; identifier starts at byte 1
    wire [7:0] frame_len   = sram[0];
    wire [7:0] cur_byte    = sram[ptr_reg];
    wire       cur_bit     = cur_byte[bit_reg]; // R2
    wire       active      = state_reg != pnpiso_pkg::WAIT_KEY; // R19
    wire       numbered    = csn_reg != 8'h00;
    wire       in_iso      = state_reg == pnpiso_pkg::ISOLATE;
    // Reads past the last pair are ignored, so a host overrun cannot drive stale bits
    wire       iso_take    = in_iso && iso_read && !lost_reg && pair_cnt_reg != `PNPISO_PAIRS; // R3
    wire       pair_done   = iso_take && half_reg;
    wire       sense_first = sd_sync_reg == `PNPISO_SENSE_FIRST; // R7
    wire       sense_sec   = sd_sync_reg == `PNPISO_SENSE_SECOND; // R7
    wire       lose_now    = pair_done && !drove_reg && sensed_reg && sense_sec; // R6
    wire       wake_any    = active && wake_cmd;
    wire       wake_zero   = wake_any && wake_data == `PNPISO_WAKE_ISOLATE;
    wire       res_take    = res_read && state_reg == pnpiso_pkg::CONFIG; // R22
    wire       wrap_ptr    = {2'b00, ptr_reg} == frame_len;
    wire       csn_clear   = active && (reset_csn_cmd || vendor_select_number_clear); // R15
    wire       csn_set     = active && csn_write && in_iso && !lost_reg;

    assign cmd_enabled = numbered; // R9
    assign card_state  = state_reg;
    assign csn         = csn_reg;
    assign sd_out      = sd_out_reg;
    assign sd_oe       = sd_oe_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            pnpiso_pkg::WAIT_KEY:
                if (key_detected)
                    state_next = pnpiso_pkg::SLEEP; // R19
            pnpiso_pkg::SLEEP:
                if (wake_zero && !numbered)
                    state_next = pnpiso_pkg::ISOLATE; // R20
                else if (wake_any && numbered && wake_data == csn_reg)
                    state_next = pnpiso_pkg::CONFIG; // R22
            pnpiso_pkg::ISOLATE:
                if (csn_set && csn_data != 8'h00)
                    state_next = pnpiso_pkg::CONFIG; // R21
                else if (lose_now || (wake_any && !wake_zero))
                    state_next = pnpiso_pkg::SLEEP;
            pnpiso_pkg::CONFIG:
                if (wake_any && wake_data != csn_reg)
                    state_next = pnpiso_pkg::SLEEP; // R21
            default:
                state_next = pnpiso_pkg::WAIT_KEY;
        endcase
        if (wait_key_cmd)
            state_next = pnpiso_pkg::WAIT_KEY; // R14
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= pnpiso_pkg::WAIT_KEY; // R14
            csn_reg   <= 8'h00; // R18
        end
        else
        begin
            state_reg <= state_next;
            // A number write beats a clear in the same cycle
            if (csn_set)
                csn_reg <= csn_data;
            else if (csn_clear)
                csn_reg <= 8'h00; // R15
        end
    end

    // Pointer, bit and pair tracking
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_reg      <= `PNPISO_FIXED_START; // R20
            bit_reg      <= 3'd0;
            half_reg     <= 1'b0;
            lost_reg     <= 1'b0;
            drove_reg    <= 1'b0;
            sensed_reg   <= 1'b0;
            pair_cnt_reg <= 8'h00;
        end
        else if (wake_any)
        begin
            ptr_reg      <= `PNPISO_FIXED_START; // R20
            bit_reg      <= 3'd0;
            half_reg     <= 1'b0;
            // A loss in the same cycle as a wake still counts
            lost_reg     <= lose_now; // R6
            pair_cnt_reg <= 8'h00;
        end
        else if (iso_take && pair_cnt_reg != `PNPISO_PAIRS)
        begin
            half_reg <= !half_reg;
            if (!half_reg)
            begin
                drove_reg  <= cur_bit; // R4
                sensed_reg <= sense_first; // R4
            end
            else if (lose_now)
                lost_reg <= 1'b1; // R6
            else
            begin
                pair_cnt_reg <= pair_cnt_reg + 8'd1; // R3
                bit_reg      <= bit_reg + 3'd1; // R8
                if (bit_reg == 3'd7)
                    ptr_reg <= ptr_reg + 6'd1; // R8
            end
        end
        else if (res_take)
            ptr_reg <= wrap_ptr ? `PNPISO_FIXED_START : ptr_reg + 6'd1; // R17
    end

    // Bus drive is registered; the sensing card leaves the bus floating
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sd_out_reg <= 8'h00;
            sd_oe_reg  <= 1'b0;
        end
        else if (iso_take && cur_bit)
        begin
            sd_out_reg <= half_reg ? `PNPISO_DRIVE_SECOND : `PNPISO_DRIVE_FIRST; // R5
            sd_oe_reg  <= 1'b1; // R7
        end
        else if (res_take)
        begin
            sd_out_reg <= cur_byte; // R17
            sd_oe_reg  <= 1'b1;
        end
        else
        begin
            sd_out_reg <= 8'h00;
            sd_oe_reg  <= 1'b0;
        end
    end

    a_drive_pattern: assert property (@(posedge clk) disable iff (rst) // R4
        iso_take && cur_bit && !half_reg |=> sd_oe && sd_out == 8'h55)
        else $error("first isolation read did not drive 55h");
    a_second_pattern: assert property (@(posedge clk) disable iff (rst) // R5
        iso_take && cur_bit && half_reg |=> sd_oe && sd_out == 8'haa)
        else $error("second isolation read did not drive aah");
    a_zero_floats: assert property (@(posedge clk) disable iff (rst) // R4
        iso_take && !cur_bit |=> !sd_oe)
        else $error("zero bit card drove the bus");
    a_loser_sleeps: assert property (@(posedge clk) disable iff (rst) // R6
        lose_now && !wait_key_cmd && !csn_set |=> state_reg == pnpiso_pkg::SLEEP)
        else $error("losing card stayed in isolation");
    a_wake_rewinds: assert property (@(posedge clk) disable iff (rst) // R20
        wake_any |=> ptr_reg == 6'd1 && bit_reg == 3'd0)
        else $error("wake did not rewind pointer");
    a_wait_key_cmd: assert property (@(posedge clk) disable iff (rst) // R14
        wait_key_cmd |=> state_reg == pnpiso_pkg::WAIT_KEY)
        else $error("wait for key command ignored");
    a_res_only_config: assert property (@(posedge clk) disable iff (rst) // R22
        res_read && state_reg != pnpiso_pkg::CONFIG && !iso_take |=> !sd_oe)
        else $error("resource data read outside configuration");
    a_csn_clear: assert property (@(posedge clk) disable iff (rst) // R15
        csn_clear && !csn_set |=> csn_reg == 8'h00)
        else $error("reset command did not clear number");
    a_key_ignored: assert property (@(posedge clk) disable iff (rst) // R19
        state_reg == pnpiso_pkg::WAIT_KEY && !key_detected |=> state_reg == pnpiso_pkg::WAIT_KEY)
        else $error("left key wait without key");
    a_res_advance: assert property (@(posedge clk) disable iff (rst) // R17
        res_take && !wake_any && !wrap_ptr |=> ptr_reg == $past(ptr_reg) + 6'd1)
        else $error("resource pointer did not advance");

    // Pair limit, resource answers, number assignment and wake moves
    a_pair_limit: assert property (@(posedge clk) disable iff (rst) // R3
        in_iso && iso_read && pair_cnt_reg == `PNPISO_PAIRS |=> !sd_oe)
        else $error("read past the last pair drove the bus");
    a_res_drive: assert property (@(posedge clk) disable iff (rst) // R17
        res_take |=> sd_oe && sd_out == $past(cur_byte))
        else $error("resource read did not return the pointed byte");
    a_res_wrap: assert property (@(posedge clk) disable iff (rst) // R17
        res_take && !wake_any && wrap_ptr |=> ptr_reg == `PNPISO_FIXED_START)
        else $error("resource pointer did not wrap");
    a_csn_assign: assert property (@(posedge clk) disable iff (rst) // R21
        csn_set && csn_data != 8'h00 && !wait_key_cmd |=> state_reg == pnpiso_pkg::CONFIG)
        else $error("numbered card did not enter configuration");
    a_csn_latch: assert property (@(posedge clk) disable iff (rst) // R21
        csn_set |=> csn_reg == $past(csn_data))
        else $error("number write did not land");
    a_sleep_isolate: assert property (@(posedge clk) disable iff (rst) // R20
        state_reg == pnpiso_pkg::SLEEP && wake_zero && !numbered && !wait_key_cmd
        |=> state_reg == pnpiso_pkg::ISOLATE)
        else $error("unnumbered card did not enter isolation");
    a_numbered_skip: assert property (@(posedge clk) disable iff (rst) // R9
        state_reg == pnpiso_pkg::SLEEP && wake_zero && numbered && !wait_key_cmd
        |=> state_reg == pnpiso_pkg::SLEEP)
        else $error("numbered card joined isolation");
endmodule // pnpiso_card

// file: bench/pnpiso_bus_model.sv
// Partner model: a rival card and the floating data lines seen by the card
`timescale 1ns/1ps
module pnpiso_bus_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       rival_on,
    input  wire logic       iso_read,
    input  wire logic       wake_cmd,
    input  wire logic [7:0] sd_out,
    input  wire logic       sd_oe,
    output logic      [1:0] sd_in
);
    logic second_reg;
    logic flip_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            second_reg <= 1'b0;
            flip_reg   <= 1'b0;
        end
        else
        begin
            flip_reg <= ~flip_reg;
            if (wake_cmd)
                second_reg <= 1'b0;
            else if (iso_read)
                second_reg <= ~second_reg;
        end
    end

    // Released lines toggle every cycle, so a stale value never passes for a rival
    assign sd_in = sd_oe ? sd_out[1:0] : rival_on ? (second_reg ? 2'b10 : 2'b01) : {2{flip_reg}};
endmodule // pnpiso_bus_model

// file: bench/tb_top.sv
// Self-checking bench for the card isolation block
`timescale 1ns/1ps
module tb_top;
    logic                         clk;
    logic                         rst;
    logic [7:0]                   p;
    logic [7:0]                   cmd_data;
    logic                         rival_on;
    logic                         load_valid;
    logic                         load_ready;
    pnpiso_pkg::pnpiso_load_type  load_word;
    logic [1:0]                   sd_in;
    logic [7:0]                   sd_out;
    logic                         sd_oe;
    pnpiso_pkg::pnpiso_state_type card_state;
    logic [7:0]                   csn;
    logic                         cmd_enabled;
    logic [7:0]                   mem [0:12];
    logic [7:0]                   exp_q [$];
    int                           err_total;
    int                           checked;
    int                           host_ones;
    int                           exp_ones;

    pnpiso_card pnpiso_card_i (.clk(clk), .rst(rst), .key_detected(p[0]), .wait_key_cmd(p[1]), .wake_cmd(p[2]),
        .wake_data(cmd_data), .csn_write(p[3]), .csn_data(cmd_data), .reset_csn_cmd(p[4]),
        .vendor_select_number_clear(p[5]), .iso_read(p[6]), .res_read(p[7]), .sd_in(sd_in), .sd_out(sd_out),
        .sd_oe(sd_oe), .load_valid(load_valid), .load_ready(load_ready), .load_word(load_word),
        .card_state(card_state), .csn(csn), .cmd_enabled(cmd_enabled));

    pnpiso_bus_model pnpiso_bus_model_i (.clk(clk), .rst(rst), .rival_on(rival_on), .iso_read(p[6]),
        .wake_cmd(p[2]), .sd_out(sd_out), .sd_oe(sd_oe), .sd_in(sd_in));

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic st(input pnpiso_pkg::pnpiso_state_type s, input logic [7:0] c);
        chk("card_state", {6'h00, s}, {6'h00, card_state});
        chk("csn", c, csn);
    endtask

    // Idle gap after each pulse keeps sensed lines settled ahead of the next read
    // The host's long waits between reads shrink to this gap
    task automatic pulse(input int i, input logic [7:0] d);
        @(negedge clk);
        p[i]     = 1'b1;
        cmd_data = d;
        @(negedge clk);
        p = 8'h00;
        repeat (3) @(negedge clk);
    endtask

    task automatic iso_pair(input logic b);
        if (b)
            exp_q.push_back(8'h55);
        pulse(6, 8'h00);
        if (b)
            exp_q.push_back(8'haa);
        pulse(6, 8'h00);
    endtask

    task automatic load_all();
        int n;
        for (int a = 0; a < 13; a++)
        begin
            @(negedge clk);
            load_valid = 1'b1;
            load_word  = '{addr: a[5:0], data: mem[a]};
            n = 0;
            // Ready only moves on a rising edge, so here it shows what the next edge samples
            while (load_ready !== 1'b1 && n < 100)
            begin
                n++;
                @(negedge clk);
            end
            if (n == 100)
            begin
                err_total++;
                finish_test();
            end
        end
        @(negedge clk);
        load_valid = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // Every driven answer must match the oldest noted expectation
    always @(posedge clk)
    begin
        if (sd_oe === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected sd_oe", 8'h00, 8'h01);
            else
            begin
                if (sd_out === 8'haa)
                    host_ones++;
                chk("sd_out", exp_q.pop_front(), sd_out);
            end
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial
    begin
        rst        = 1'b1;
        p          = 8'h00;
        cmd_data   = 8'h00;
        rival_on   = 1'b0;
        load_valid = 1'b0;
        load_word  = '0;
        err_total  = 0;
        checked    = 0;
        host_ones  = 0;
        exp_ones   = 0;
        void'($urandom(32'h2d13842e));
        mem[0] = 8'h0c;
        for (int i = 1; i < 13; i++)
            mem[i] = 8'($urandom);
        mem[1] = (mem[1] & 8'hfc) | 8'h02;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        st(pnpiso_pkg::WAIT_KEY, 8'h00);
        load_all();
        pulse(2, 8'h00);
        st(pnpiso_pkg::WAIT_KEY, 8'h00);
        pulse(0, 8'h00);
        st(pnpiso_pkg::SLEEP, 8'h00);
        // The rival's pattern must pass the synchroniser well before the first read
        rival_on = 1'b1;
        pulse(2, 8'h00);
        st(pnpiso_pkg::ISOLATE, 8'h00);
        iso_pair(mem[1][0]);
        st(pnpiso_pkg::SLEEP, 8'h00);
        chk("host ones", 8'h00, 8'(host_ones));
        rival_on = 1'b0;
        pulse(2, 8'h00);
        st(pnpiso_pkg::ISOLATE, 8'h00);
        for (int k = 0; k < 72; k++)
        begin
            exp_ones += int'(mem[1 + k / 8][k % 8]);
            iso_pair(mem[1 + k / 8][k % 8]);
        end
        chk("host ones", 8'(exp_ones), 8'(host_ones));
        pulse(6, 8'h00);
        st(pnpiso_pkg::ISOLATE, 8'h00);
        pulse(3, 8'h01);
        st(pnpiso_pkg::CONFIG, 8'h01);
        chk("cmd_enabled", 8'h01, {7'h00, cmd_enabled});
        for (int k = 0; k < 14; k++)
        begin
            // Isolation left the pointer just past the identifier, so reads begin at the resources
            exp_q.push_back(mem[k < 3 ? k + 10 : k - 2]);
            pulse(7, 8'h00);
        end
        pulse(2, 8'h00);
        st(pnpiso_pkg::SLEEP, 8'h01);
        pulse(7, 8'h00);
        pulse(6, 8'h00);
        pulse(2, 8'h00);
        st(pnpiso_pkg::SLEEP, 8'h01);
        pulse(2, 8'h01);
        st(pnpiso_pkg::CONFIG, 8'h01);
        exp_q.push_back(mem[1]);
        pulse(7, 8'h00);
        pulse(4, 8'h00);
        chk("csn", 8'h00, csn);
        chk("cmd_enabled", 8'h00, {7'h00, cmd_enabled});
        pulse(1, 8'h00);
        st(pnpiso_pkg::WAIT_KEY, 8'h00);
        pulse(0, 8'h00);
        pulse(2, 8'h00);
        pulse(3, 8'h03);
        st(pnpiso_pkg::CONFIG, 8'h03);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        st(pnpiso_pkg::WAIT_KEY, 8'h00);
        pulse(0, 8'h00);
        pulse(2, 8'h00);
        pulse(3, 8'h05);
        st(pnpiso_pkg::CONFIG, 8'h05);
        pulse(5, 8'h00);
        chk("csn", 8'h00, csn);
        chk("pending answers", 8'h00, 8'(exp_q.size()));
        finish_test();
    end
endmodule // tb_top
